// file: common/eppc_pkg.sv
// package: constants, states and bus carriers of the epp 1.7 cycle engine
`default_nettype none
package eppc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_EPP_ADDR = 8'h0c;
  localparam logic [7:0] OFS_EPP_DATA = 8'h10;
  // control field positions
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOFD = 1;
  localparam int CTL_INIT = 2;
  localparam int CTL_SELECTIN = 3;
  localparam int CTL_IRQ_EN = 4;
  localparam int CTL_DIR = 5;
  // status field positions
  localparam int STS_TIMEOUT = 0;
  localparam int STS_NFAULT = 3;
  localparam int STS_SELECT = 4;
  localparam int STS_PERROR = 5;
  localparam int STS_INTR = 6;
  localparam int STS_NBUSY = 7;
  // reset values; init bit set keeps the peripheral out of reset
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [5:0] RST_CONTROL = 6'h04;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WDOG_TIME_NS = 10000;
  localparam int WDOG_CYCLES_INT = WDOG_TIME_NS / CLK_PERIOD_NS;
  localparam logic [10:0] WDOG_CYCLES = 11'(WDOG_CYCLES_INT);
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_WSET = 5'b00010,
    S_WSTB = 5'b00100,
    S_RSTB = 5'b01000,
    S_RESP = 5'b10000
  } eppc_state_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } eppc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } eppc_axi_rsp_t;
endpackage
`default_nettype wire

// file: hdl/eppc_cycle_engine.sv
// module: epp 1.7 cycle engine with axi4-lite registers and cycle watchdog
//
// Contract
// - idle port follows standard control register
// - watchdog runs for the whole host strobe
// - timeout aborts cycle, sets status bit 0
// - ioChrdy low while nWait low in cycle
// - cycle completes only with nWait high
// - write drives host byte onto port bus
// - then assert data or address strobe
// - hold ioChrdy until nWait release or timeout
// - strobe drops, host byte stays latched
// - after cycle outputs may change freely
// - read end drops strobe; peripheral releases bus
// - nWrite, nDataStb, nAddrStb all active low
// - interrupt rising-edge, passed through uninverted
// - active-low reset output to peripheral
// - direction low unless control bit or read
// - nWrite, nStrobe, nAutoFd, nSelectIn, nReset keep following control during cycles
`default_nettype none
module eppc_cycle_engine
  import eppc_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  // register bus
  input wire eppc_axi_req_t axiReq,
  output eppc_axi_rsp_t axiRsp,
  // parallel data bus
  input wire logic [7:0] portDataIn,
  output logic [7:0] portDataOut,
  output logic portDataOe,
  output logic port_direction_out,
  // epp strobes and handshake
  output logic nWrite,
  output logic nDataStb,
  output logic nAddrStb,
  input wire logic nWait,
  output logic ioChrdy,
  // standard port lines
  output logic nStrobe,
  output logic nAutoFd,
  output logic nSelectIn,
  output logic nReset,
  input wire logic intrIn,
  output logic intrOut,
  input wire logic nFault,
  input wire logic select,
  input wire logic pError
);

  eppc_state_t state_reg;
  logic [7:0] data_reg;
  logic [7:0] rdByte_reg;
  logic [5:0] control_reg;
  logic timeout_reg;
  logic isAddr_reg;
  logic abort_reg;
  logic [10:0] wdogCnt_reg;
  logic awHave_reg;
  logic wHave_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic bValid_reg;
  logic [1:0] bResp_reg;
  logic rValid_reg;
  logic [1:0] rResp_reg;
  logic [31:0] rData_reg;
  logic rdCycle_reg;
  logic inStb;
  logic wrStart;
  logic rdStart;
  logic wdogFire;
  logic stsRead;
  logic [7:0] statusByte;
  logic arMapped;
  logic controlDir;

  assign controlDir = control_reg[CTL_DIR];
  assign inStb = (state_reg == S_WSTB) || (state_reg == S_RSTB);
  // more than the watchdog time with the peripheral still holding off
  assign wdogFire = inStb && !nWait && (wdogCnt_reg >= WDOG_CYCLES);
  assign wrStart = (state_reg == S_IDLE) && awHave_reg && wHave_reg;
  // writes win over reads when both wait in the same cycle
  assign rdStart = (state_reg == S_IDLE) && !wrStart && axiReq.arvalid && !rValid_reg;
  assign stsRead = rdStart && (axiReq.araddr == OFS_STATUS);
  assign arMapped = (axiReq.araddr == OFS_DATA) || (axiReq.araddr == OFS_STATUS) ||
                    (axiReq.araddr == OFS_CONTROL);
  assign statusByte = {nWait, intrIn, pError, select, nFault, 2'b00, timeout_reg};

  // bus slave handshake
  // no handshake while frozen, or a taken request would be lost
  assign axiRsp.awready = !awHave_reg && clkEn;
  assign axiRsp.wready = !wHave_reg && clkEn;
  assign axiRsp.bvalid = bValid_reg;
  assign axiRsp.bresp = bResp_reg;
  assign axiRsp.arready = rdStart && clkEn;
  assign axiRsp.rvalid = rValid_reg;
  assign axiRsp.rresp = rResp_reg;
  assign axiRsp.rdata = rData_reg;

  // pins
  assign portDataOut = data_reg;
  // write cycle forces the drive on, read cycle forces it off
  assign portDataOe = (state_reg == S_WSET || state_reg == S_WSTB) ? 1'b1 :
                      rdCycle_reg ? 1'b0 : !controlDir;
  assign port_direction_out = controlDir || rdCycle_reg;
  assign nWrite = controlDir;
  assign nDataStb = !(inStb && !isAddr_reg);
  assign nAddrStb = !(inStb && isAddr_reg);
  assign ioChrdy = !(inStb && !nWait);
  assign nStrobe = !control_reg[CTL_STROBE];
  assign nAutoFd = !control_reg[CTL_AUTOFD];
  assign nSelectIn = !control_reg[CTL_SELECTIN];
  assign nReset = control_reg[CTL_INIT];
  assign intrOut = intrIn && control_reg[CTL_IRQ_EN];

  // write address and data are captured independently, in either order
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end
    else if (clkEn)
    begin
      if (axiReq.awvalid && !awHave_reg)
      begin
        awHave_reg <= 1'b1;
        awAddr_reg <= axiReq.awaddr;
      end
      else if (wrStart)
        awHave_reg <= 1'b0;
      if (axiReq.wvalid && !wHave_reg)
      begin
        wHave_reg <= 1'b1;
        wData_reg <= axiReq.wdata;
        wStrb_reg <= axiReq.wstrb;
      end
      else if (wrStart)
        wHave_reg <= 1'b0;
    end
  end

  // cycle sequencer
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg <= S_IDLE;
      isAddr_reg <= 1'b0;
      rdCycle_reg <= 1'b0;
      abort_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      case (state_reg)
        S_IDLE:
        begin
          abort_reg <= 1'b0;
          if (wrStart && (awAddr_reg == OFS_EPP_ADDR || awAddr_reg == OFS_EPP_DATA))
          begin
            isAddr_reg <= (awAddr_reg == OFS_EPP_ADDR);
            state_reg <= S_WSET;
          end
          else if (rdStart && (axiReq.araddr == OFS_EPP_ADDR ||
                               axiReq.araddr == OFS_EPP_DATA))
          begin
            isAddr_reg <= (axiReq.araddr == OFS_EPP_ADDR);
            rdCycle_reg <= 1'b1;
            state_reg <= S_RSTB;
          end
          else if (wrStart || rdStart)
            state_reg <= S_RESP;
        end
        // one cycle of byte setup before the strobe
        S_WSET:
          state_reg <= S_WSTB;
        S_WSTB, S_RSTB:
        begin
          if (nWait)
            state_reg <= S_RESP;
          else if (wdogFire)
          begin
            abort_reg <= 1'b1;
            state_reg <= S_RESP;
          end
        end
        S_RESP:
        begin
          if (!bValid_reg && !rValid_reg)
          begin
            rdCycle_reg <= 1'b0;
            state_reg <= S_IDLE;
          end
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

  // watchdog spans the whole strobe of the cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      wdogCnt_reg <= 11'h000;
    else if (clkEn)
    begin
      if (!inStb)
        wdogCnt_reg <= 11'h000;
      else if (wdogCnt_reg < WDOG_CYCLES)
        wdogCnt_reg <= wdogCnt_reg + 11'h001;
    end
  end

  // timeout flag: set wins over the clear-on-read of status
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      timeout_reg <= 1'b0;
    else if (clkEn)
    begin
      if (wdogFire)
        timeout_reg <= 1'b1;
      else if (stsRead)
        timeout_reg <= 1'b0;
    end
  end

  // shared data register and control register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      data_reg <= RST_DATA;
      control_reg <= RST_CONTROL;
    end
    else if (clkEn && wrStart && wStrb_reg[0])
    begin
      // epp writes land in the common data register and stay on the bus after
      if (awAddr_reg == OFS_DATA || awAddr_reg == OFS_EPP_ADDR ||
          awAddr_reg == OFS_EPP_DATA)
        data_reg <= wData_reg[7:0];
      else if (awAddr_reg == OFS_CONTROL)
        control_reg <= wData_reg[5:0];
    end
  end

  // read byte latched when the peripheral releases nWait
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rdByte_reg <= 8'h00;
    else if (clkEn && state_reg == S_RSTB && nWait)
      rdByte_reg <= portDataIn;
  end

  // responses
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bValid_reg <= 1'b0;
      bResp_reg <= RESP_OKAY;
      rValid_reg <= 1'b0;
      rResp_reg <= RESP_OKAY;
      rData_reg <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      if (bValid_reg && axiReq.bready)
        bValid_reg <= 1'b0;
      if (rValid_reg && axiReq.rready)
        rValid_reg <= 1'b0;
      if (wrStart && !(awAddr_reg == OFS_EPP_ADDR || awAddr_reg == OFS_EPP_DATA))
      begin
        bValid_reg <= 1'b1;
        bResp_reg <= (awAddr_reg == OFS_DATA || awAddr_reg == OFS_CONTROL ||
                      awAddr_reg == OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rdStart && arMapped)
      begin
        rValid_reg <= 1'b1;
        rResp_reg <= RESP_OKAY;
        rData_reg <= (axiReq.araddr == OFS_DATA) ? {24'h000000, data_reg} :
                     (axiReq.araddr == OFS_STATUS) ? {24'h000000, statusByte} :
                     {26'h0000000, control_reg};
      end
      else if (rdStart && !(axiReq.araddr == OFS_EPP_ADDR ||
                            axiReq.araddr == OFS_EPP_DATA))
      begin
        rValid_reg <= 1'b1;
        rResp_reg <= RESP_SLVERR;
        rData_reg <= 32'h0000_0000;
      end
      else if (state_reg == S_WSTB && (nWait || wdogFire))
      begin
        bValid_reg <= 1'b1;
        bResp_reg <= nWait ? RESP_OKAY : RESP_SLVERR;
      end
      else if (state_reg == S_RSTB && (nWait || wdogFire))
      begin
        rValid_reg <= 1'b1;
        rResp_reg <= nWait ? RESP_OKAY : RESP_SLVERR;
        rData_reg <= {24'h000000, nWait ? portDataIn : 8'h00};
      end
    end
  end

  // checks
  AST_WDOG_FIRE: assert property (@(posedge clk_sys) disable iff (rst)
    wdogFire |-> wdogCnt_reg == WDOG_CYCLES && inStb)
    else $error("watchdog fired before its time");
  AST_TIMEOUT_SET: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && wdogFire |=> timeout_reg && state_reg == S_RESP && nDataStb && nAddrStb)
    else $error("timeout did not abort and flag");
  AST_CHRDY: assert property (@(posedge clk_sys) disable iff (rst)
    inStb && !nWait |-> !ioChrdy)
    else $error("ioChrdy released while nWait low");
  AST_COMPLETE: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && inStb && !nWait && !wdogFire |=> state_reg == $past(state_reg))
    else $error("cycle ended while nWait low");
  AST_WRITE_BUS: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == S_WSTB |-> portDataOe && !port_direction_out == !controlDir)
    else $error("write byte not driven");
  AST_SETUP: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && state_reg == S_WSET |=> (!nDataStb || !nAddrStb) && $stable(portDataOut))
    else $error("write strobe not after setup");
  AST_STB_DROP: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && inStb && nWait |=> nDataStb && nAddrStb && (bValid_reg || rValid_reg))
    else $error("strobe not dropped at cycle end");
  AST_READ_BUS: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == S_RSTB |-> !portDataOe && port_direction_out)
    else $error("read strobe with bus driven");
  AST_ONE_STB: assert property (@(posedge clk_sys) disable iff (rst)
    !(!nDataStb && !nAddrStb))
    else $error("both strobes active");
  AST_DIR: assert property (@(posedge clk_sys) disable iff (rst)
    port_direction_out |-> controlDir || rdCycle_reg)
    else $error("direction high without cause");
  COV_WRITE: cover property (@(posedge clk_sys) state_reg == S_WSTB ##1 state_reg == S_RESP);
  COV_READ: cover property (@(posedge clk_sys) state_reg == S_RSTB ##1 state_reg == S_RESP);
  COV_TIMEOUT: cover property (@(posedge clk_sys) wdogFire);
  COV_ADDR: cover property (@(posedge clk_sys) !nAddrStb && !nWait);

endmodule
`default_nettype wire

// file: verification/eppc_periph.sv
// peripheral model: answers epp strobes through nWait, drives read bytes
`default_nettype none
module eppc_periph
  import eppc_pkg::*;
(
  // clock, reset
  input wire logic clk_sys,
  input wire logic rst,
  // epp lines
  input wire logic nDataStb,
  input wire logic nAddrStb,
  input wire logic [7:0] portDataOut,
  input wire logic portDataOe,
  output logic nWait,
  output logic [7:0] portDataIn,
  // bench control
  input wire logic [7:0] rdByte,
  input wire logic [3:0] dly,
  input wire logic hang,
  output logic [7:0] gotByte,
  output logic gotAddr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  logic [7:0] drv;
  logic drvOn;
  // no pull on the bus, so a released bus shows the inverse of the last byte
  assign portDataIn = drvOn ? drv : ~drv;
  always_ff @(posedge clk_sys)
  begin
    if (rst || (nDataStb && nAddrStb))
    begin
      if (rst)
        drv <= 8'h5a;
      cnt <= 4'h0;
      nWait <= 1'b0;
      drvOn <= 1'b0;
    end
    else if (!nWait && !hang)
    begin
      cnt <= cnt + 4'h1;
      if (cnt == dly)
      begin
        drv <= rdByte;
        drvOn <= !portDataOe;
      end
      if (cnt == dly + 4'h1)
      begin
        nWait <= 1'b1;
        gotByte <= portDataOut;
        gotAddr <= !nAddrStb;
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// bench: axi4-lite host, peripheral model, random and corner cycles
`default_nettype none
module tb_top
  import eppc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst, clkEn, nWait, ioChrdy, intrIn, intrOut, nFault, select, pError;
  logic [7:0] portDataIn, portDataOut, rdByte, gotByte, b, a;
  logic portDataOe, port_direction_out, nWrite, nDataStb, nAddrStb, hang, gotAddr;
  logic nStrobe, nAutoFd, nSelectIn, nReset;
  logic [3:0] dly;
  logic [31:0] d;
  logic [1:0] r;
  logic [7:0] cv [4] = '{8'hcb, 8'h34, 8'h10, 8'h00};
  eppc_axi_req_t axiReq;
  eppc_axi_rsp_t axiRsp;
  int bad_count, samples_checked, stbCnt;
  eppc_cycle_engine dut_u (.clk_sys, .rst, .clkEn, .axiReq, .axiRsp, .portDataIn,
    .portDataOut, .portDataOe, .port_direction_out, .nWrite, .nDataStb, .nAddrStb,
    .nWait, .ioChrdy, .nStrobe, .nAutoFd, .nSelectIn, .nReset, .intrIn, .intrOut,
    .nFault, .select, .pError);
  eppc_periph periph_u (.clk_sys, .rst, .nDataStb, .nAddrStb, .portDataOut,
    .portDataOe, .nWait, .portDataIn, .rdByte, .dly, .hang, .gotByte, .gotAddr);
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chkv(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chkr(input logic [1:0] got, input logic [1:0] exp, input string m);
    chkv(32'(got), 32'(exp), m);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // address and data are offered together, each dropped once taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
    @(posedge clk_sys);
    axiReq.awaddr <= ad;
    axiReq.awvalid <= 1'b1;
    axiReq.wdata <= dt;
    axiReq.wstrb <= 4'hf;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (axiRsp.awready)
        axiReq.awvalid <= 1'b0;
      if (axiRsp.wready)
        axiReq.wvalid <= 1'b0;
    end
    while (!axiRsp.bvalid);
    rs = axiRsp.bresp;
    axiReq.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    @(posedge clk_sys);
    axiReq.araddr <= ad;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (axiRsp.arready)
        axiReq.arvalid <= 1'b0;
    end
    while (!axiRsp.rvalid);
    dt = axiRsp.rdata;
    rs = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask
  task automatic ctl(input logic [7:0] v);
    wr(OFS_CONTROL, {24'h0, v}, r);
    chkr(r, RESP_OKAY, "ctl wr");
    @(negedge clk_sys);
  endtask
  // strobe phase monitor; hold-off must track nWait exactly
  always @(negedge clk_sys)
    if (!rst && !(nDataStb && nAddrStb))
    begin
      stbCnt++;
      chkv(32'(ioChrdy), 32'(nWait), "ready");
      chkv(32'(portDataOe), 32'(!port_direction_out), "bus dir");
    end
  initial
  begin
    #600000;
    bad_count++;
    $display("BAD t=%0t watchdog expired", $time);
    end_sim();
  end
  initial
  begin
    axiReq = '0;
    {clkEn, rst} = 2'b11;
    {intrIn, nFault, select, pError, hang} = '0;
    rdByte = 8'h00;
    dly = 4'h0;
    {bad_count, samples_checked, stbCnt} = '0;
    void'($urandom(70));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chkv(32'({nReset, nWrite, port_direction_out}), 32'h4, "rst pins");
    rd(OFS_CONTROL, d, r);
    chkv(d, 32'(RST_CONTROL), "ctl rst");
    $display("reset test done");
    @(posedge clk_sys);
    intrIn <= 1'b1;
    foreach (cv[i])
    begin
      ctl(cv[i]);
      chkv(32'({nStrobe, nAutoFd, nSelectIn, nReset}),
        32'({~cv[i][0], ~cv[i][1], ~cv[i][3], cv[i][2]}), "std");
      chkv(32'(port_direction_out), 32'(cv[i][5]), "dir");
      chkv(32'(nWrite), 32'(cv[i][5]), "nwrite");
      chkv(32'(intrOut), 32'(cv[i][4]), "intr");
      rd(OFS_CONTROL, d, r);
      chkv(d, 32'(cv[i][5:0]), "ctl rb");
    end
    @(posedge clk_sys);
    {intrIn, nFault, select, pError} <= 4'($urandom);
    @(negedge clk_sys);
    rd(OFS_STATUS, d, r);
    chkv(d, {24'h0, nWait, intrIn, pError, select, nFault, 3'h0}, "status");
    $display("control test done");
    ctl(8'h04);
    repeat (8)
    begin
      b = 8'($urandom);
      a = ($urandom % 2) ? OFS_EPP_ADDR : OFS_EPP_DATA;
      @(posedge clk_sys);
      dly <= 4'($urandom % 8);
      wr(a, {24'h0, b}, r);
      chkr(r, RESP_OKAY, "wr resp");
      chkv(32'(gotByte), 32'(b), "wr byte");
      chkv(32'(gotAddr), 32'(a == OFS_EPP_ADDR), "wr kind");
      @(negedge clk_sys);
      chkv(32'(portDataOut), 32'(b), "latched");
    end
    rd(OFS_DATA, d, r);
    chkv(d, 32'(b), "data rb");
    $display("write test done");
    ctl(8'h24);
    repeat (8)
    begin
      a = ($urandom % 2) ? OFS_EPP_ADDR : OFS_EPP_DATA;
      @(posedge clk_sys);
      rdByte <= 8'($urandom);
      dly <= 4'($urandom % 8);
      rd(a, d, r);
      chkr(r, RESP_OKAY, "rd resp");
      chkv(d, 32'(rdByte), "rd byte");
      chkv(32'(gotAddr), 32'(a == OFS_EPP_ADDR), "rd kind");
    end
    $display("read test done");
    for (int i = 0; i < 2; i++)
    begin
      ctl(i ? 8'h24 : 8'h04);
      @(posedge clk_sys);
      hang <= 1'b1;
      stbCnt = 0;
      // freeze mid-strobe: the watchdog must stop with the rest of the state
      fork
        if (i)
          rd(OFS_EPP_DATA, d, r);
        else
          wr(OFS_EPP_DATA, 32'h5a, r);
        begin
          repeat (20) @(posedge clk_sys);
          clkEn <= 1'b0;
          repeat (50) @(posedge clk_sys);
          clkEn <= 1'b1;
        end
      join
      chkr(r, RESP_SLVERR, "abort");
      chkv(32'(stbCnt >= WDOG_CYCLES_INT + 50 && stbCnt <= WDOG_CYCLES_INT + 52), 1, "span");
      @(posedge clk_sys);
      hang <= 1'b0;
      rd(OFS_STATUS, d, r);
      chkv(d & 32'h1, 32'h1, "to flag");
      rd(OFS_STATUS, d, r);
      chkv(d & 32'h1, 32'h0, "to clear");
    end
    rd(8'h3c, d, r);
    chkr(r, RESP_SLVERR, "unmapped");
    wr(8'h3c, 32'h1, r);
    chkr(r, RESP_SLVERR, "unmapped wr");
    wr(OFS_STATUS, 32'hff, r);
    chkr(r, RESP_OKAY, "sts wr");
    rd(OFS_STATUS, d, r);
    chkv(d & 32'h1, 32'h0, "sts ro");
    $display("timeout test done");
    end_sim();
  end
endmodule
`default_nettype wire
